// ---- hdl/pdm_defs.vh ----
// Constants shared by the poll data mapper files.
`ifndef PDM_DEFS_VH
`define PDM_DEFS_VH
// ****************************************************************
// Poll group sizes
// ****************************************************************
`define PDM_SHORT_REQ_BYTES 7'd6
`define PDM_EXT_REQ_BYTES   7'd46
`define PDM_SHORT_REQ_WORDS 5'd3
`define PDM_EXT_REQ_WORDS   5'd23
`define PDM_SHORT_RSP_WORDS 5'd9
`define PDM_EXT_RSP_WORDS   5'd15
`define PDM_BYTE_CNT_MAX    7'h7f
// ****************************************************************
// Drive register numbers and fields
// ****************************************************************
`define PDM_REG_CTRL        6'd32
`define PDM_CTRL_START_BIT  0
`define PDM_CTRL_STOP_BIT   1
`define PDM_CTRL_RESET_VAL  16'h0000
`define PDM_LOSS_SEL_FAULT  2'h1
`endif

// ---- hdl/pdm_ram.v ----
// Small register-read memory used for staging and for the drive status image.
`timescale 1ns/1ps
module pdm_ram #(
    parameter WIDTH = 16,
    parameter DEPTH = 64,
    parameter AW    = 6
) (
    // Clock
    input  wire             clk,
    input  wire             ce,
    // Write port
    input  wire             wrEn,
    input  wire [AW-1:0]    wrAddr,
    input  wire [WIDTH-1:0] wrData,
    // Read port
    input  wire             rdEn,
    input  wire [AW-1:0]    rdAddr,
    output reg  [WIDTH-1:0] rdData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];

    always @(posedge clk)
    begin
        if (ce)
        begin
            if (wrEn)
                mem[wrAddr] <= wrData;
            if (rdEn)
                rdData <= mem[rdAddr];
        end
    end
endmodule // pdm_ram

// ---- hdl/pdm_fifo.v ----
// Synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ps
module pdm_fifo #(
    parameter WIDTH = 9,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    // Clock and reset
    input  wire             clk,
    input  wire             resetn,
    input  wire             ce,
    // Fill side
    input  wire             inValid,
    output wire             inReady,
    input  wire [WIDTH-1:0] inData,
    // Drain side
    output wire             outValid,
    input  wire             outReady,
    output wire [WIDTH-1:0] outData
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW:0]      wrPtr;
    reg [AW:0]      rdPtr;
    wire            empty;
    wire            full;
    wire            push;
    wire            pop;

    assign empty    = (wrPtr == rdPtr);
    assign full     = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
    assign inReady  = ~full & ce;
    assign outValid = ~empty & ce;
    assign outData  = mem[rdPtr[AW-1:0]];
    assign push     = inValid & inReady;
    assign pop      = outValid & outReady;

    always @(posedge clk)
    begin
        if (!resetn)
        begin
            wrPtr <= {(AW+1){1'b0}};
            rdPtr <= {(AW+1){1'b0}};
        end
        else if (ce)
        begin
            if (push)
            begin
                mem[wrPtr[AW-1:0]] <= inData;
                wrPtr <= wrPtr + 1'b1;
            end
            if (pop)
                rdPtr <= rdPtr + 1'b1;
        end
    end
endmodule // pdm_fifo

// ---- hdl/pdm_mapper.v ----
// Poll message mapper between the network request/response streams and drive registers.
//
// Function
// RULE1: A request of exactly the expected byte count is accepted and answered with the input word group.
// RULE2: A request of wrong, non-zero length is discarded and gets no response.
// RULE3: Two fixed group sets exist, chosen by a configuration input, with fixed sizes and order.
// RULE4: The short set takes 3 request words and returns 9 response words.
// RULE5: The extended set adds request words after the control words and 6 response words after the status.
// RULE6: The short set consumes 6 bytes and produces 18 bytes.
// RULE7: The extended set consumes 46 bytes and produces 30 bytes.
// RULE8: A zero-length poll or strobe request clears start and stop, bits 0 and 1 of register 32.
// RULE9: Request words 0 to 2 go to registers 32, 33 and 34.
// RULE10: Extended request words 3 to 22 go to registers 37 to 49, then 51, 52, 53, 56, 57, 58 and 62.
// RULE11: Response words 0 to 8 carry registers 0 to 8.
// RULE12: Extended response words 9 to 14 carry registers 12, 13, 14, 15, 16 and 27.
// RULE13: No poll group reaches a register outside the basic set.
// RULE14: The master sends and expects exactly the byte counts of the selected set.
// RULE15: Request data reaches the regulator only while the poll connection is open.
// RULE16: Loss of the poll connection takes the selected loss action, faulting when so chosen.
// RULE17: Words travel low byte first, packed in table order.
`timescale 1ns/1ps
`include "pdm_defs.vh"
module pdm_mapper #(
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW    = 4
) (
    // Clock and reset
    input  wire        clk,
    input  wire        resetn,
    input  wire        ce,
    // Configuration
    input  wire        extSet,
    input  wire [1:0]  commLossSel,
    input  wire        pollConnOpen,
    // Request byte stream
    input  wire        reqValid,
    output wire        reqReady,
    input  wire [7:0]  reqData,
    input  wire        reqLast,
    input  wire        zeroReq,
    // Response byte stream
    output reg         rspValid,
    input  wire        rspReady,
    output reg  [7:0]  rspData,
    output reg         rspLast,
    // Drive status image write port
    input  wire        statWrEn,
    input  wire [5:0]  statWrAddr,
    input  wire [15:0] statWrData,
    // Regulator side
    output reg         regWrValid,
    output reg  [5:0]  regWrAddr,
    output reg  [15:0] regWrData,
    output reg  [15:0] ctrlWord,
    output reg         commLossFault,
    output reg         reqDropped
);
    // ****************************************************************
    // States
    // ****************************************************************
    localparam [2:0] S_RECV   = 3'd0;
    localparam [2:0] S_COMMIT = 3'd1;
    localparam [2:0] S_RSP_RD = 3'd2;
    localparam [2:0] S_RSP_LD = 3'd3;
    localparam [2:0] S_RSP_LO = 3'd4;
    localparam [2:0] S_RSP_HI = 3'd5;

    // ****************************************************************
    // Word-to-register tables
    // ****************************************************************
    // Six-bit results keep every poll access inside the basic set.
    function [5:0] cmdReg;
        input [4:0] idx;
        begin
            case (idx)
                5'd0, 5'd1, 5'd2: cmdReg = `PDM_REG_CTRL + {1'b0, idx}; // RULE9
                5'd16: cmdReg = 6'd51; // RULE10
                5'd17: cmdReg = 6'd52;
                5'd18: cmdReg = 6'd53;
                5'd19: cmdReg = 6'd56;
                5'd20: cmdReg = 6'd57;
                5'd21: cmdReg = 6'd58;
                5'd22: cmdReg = 6'd62;
                default: cmdReg = 6'd34 + {1'b0, idx}; // RULE10
            endcase
        end
    endfunction

    function [5:0] rspReg;
        input [4:0] idx;
        begin
            if (idx <= 5'd8)
                rspReg = {1'b0, idx}; // RULE11
            else if (idx <= 5'd13)
                rspReg = {1'b0, idx} + 6'd3; // RULE12
            else
                rspReg = 6'd27; // RULE12
        end
    endfunction

    // ****************************************************************
    // Declarations
    // ****************************************************************
    reg  [2:0]  state;
    reg  [6:0]  byteCnt;
    reg  [7:0]  loByte;
    reg  [4:0]  cIdx;
    reg  [4:0]  cPendIdx;
    reg         cPend;
    reg  [4:0]  rIdx;
    reg         zeroPend;
    reg         connPrev;
    reg         setLatched;
    wire [6:0]  expBytes;
    wire [4:0]  reqWords;
    wire [4:0]  rspWords;
    wire        fifoValid;
    wire        fifoReady;
    wire [8:0]  fifoData;
    wire        pop;
    wire        stWrEn;
    wire        stRdEn;
    wire [15:0] stRdData;
    wire [15:0] statRdData;
    wire        zeroService;
    wire [6:0]  nextCnt;

    // Group set is held for a whole exchange so a mid-message change cannot skew sizes.
    assign expBytes = setLatched ? `PDM_EXT_REQ_BYTES : `PDM_SHORT_REQ_BYTES; // RULE3 RULE6 RULE7
    assign reqWords = setLatched ? `PDM_EXT_REQ_WORDS : `PDM_SHORT_REQ_WORDS; // RULE4 RULE5
    assign rspWords = setLatched ? `PDM_EXT_RSP_WORDS : `PDM_SHORT_RSP_WORDS; // RULE4 RULE5

    assign zeroService = zeroPend && (state == S_RECV) && (byteCnt == 7'd0);
    assign fifoReady   = (state == S_RECV) && !zeroService && ce;
    assign pop         = fifoValid & fifoReady;
    assign nextCnt     = (byteCnt == `PDM_BYTE_CNT_MAX) ? byteCnt : byteCnt + 7'd1;
    assign stWrEn      = pop && byteCnt[0] && (byteCnt < 7'd64);
    assign stRdEn      = (state == S_COMMIT) && (cIdx < reqWords);

    // ****************************************************************
    // Buffers
    // ****************************************************************
    pdm_fifo #(
        .WIDTH (9),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) uReqFifo (
        .clk      (clk),
        .resetn   (resetn),
        .ce       (ce),
        .inValid  (reqValid),
        .inReady  (reqReady),
        .inData   ({reqLast, reqData}),
        .outValid (fifoValid),
        .outReady (fifoReady),
        .outData  (fifoData)
    );

    // Request words are staged so a wrong-length message never touches the regulator.
    pdm_ram #(
        .WIDTH (16),
        .DEPTH (32),
        .AW    (5)
    ) uStage (
        .clk    (clk),
        .ce     (ce),
        .wrEn   (stWrEn),
        .wrAddr (byteCnt[5:1]),
        .wrData ({fifoData[7:0], loByte}), // RULE17
        .rdEn   (stRdEn),
        .rdAddr (cIdx),
        .rdData (stRdData)
    );

    pdm_ram #(
        .WIDTH (16),
        .DEPTH (64),
        .AW    (6)
    ) uStatus (
        .clk    (clk),
        .ce     (ce),
        .wrEn   (statWrEn),
        .wrAddr (statWrAddr),
        .wrData (statWrData),
        .rdEn   (state == S_RSP_RD),
        .rdAddr (rspReg(rIdx)), // RULE13
        .rdData (statRdData)
    );

    // ****************************************************************
    // Connection loss handling
    // ****************************************************************
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            connPrev      <= 1'b0;
            commLossFault <= 1'b0;
        end
        else if (ce)
        begin
            connPrev <= pollConnOpen;
            if (connPrev && !pollConnOpen && commLossSel == `PDM_LOSS_SEL_FAULT)
                commLossFault <= 1'b1; // RULE16
            else if (!connPrev && pollConnOpen)
                commLossFault <= 1'b0;
        end
    end

    // A zero-length request arriving during a busy exchange is held, never lost.
    always @(posedge clk)
    begin
        if (!resetn)
            zeroPend <= 1'b0;
        else if (ce)
            zeroPend <= zeroReq | (zeroPend & ~zeroService);
    end

    // ****************************************************************
    // Message sequencer
    // ****************************************************************
    always @(posedge clk)
    begin
        if (!resetn)
        begin
            state      <= S_RECV;
            byteCnt    <= 7'd0;
            loByte     <= 8'h00;
            cIdx       <= 5'd0;
            cPendIdx   <= 5'd0;
            cPend      <= 1'b0;
            rIdx       <= 5'd0;
            setLatched <= 1'b0;
            rspValid   <= 1'b0;
            rspData    <= 8'h00;
            rspLast    <= 1'b0;
            regWrValid <= 1'b0;
            regWrAddr  <= 6'h00;
            regWrData  <= 16'h0000;
            ctrlWord   <= `PDM_CTRL_RESET_VAL;
            reqDropped <= 1'b0;
        end
        else if (ce)
        begin
            regWrValid <= 1'b0;
            reqDropped <= 1'b0;
            cPend      <= stRdEn;
            cPendIdx   <= cIdx;
            case (state)
                S_RECV:
                begin
                    if (byteCnt == 7'd0)
                        setLatched <= extSet; // RULE3
                    if (zeroService)
                    begin
                        // Stop is written even with the connection down, so the drive always halts.
                        ctrlWord[`PDM_CTRL_START_BIT] <= 1'b0; // RULE8
                        ctrlWord[`PDM_CTRL_STOP_BIT]  <= 1'b0; // RULE8
                        regWrValid <= 1'b1;
                        regWrAddr  <= `PDM_REG_CTRL;
                        regWrData  <= ctrlWord & 16'hfffc; // RULE8
                    end
                    else if (pop)
                    begin
                        if (!byteCnt[0])
                            loByte <= fifoData[7:0]; // RULE17
                        if (fifoData[8])
                        begin
                            byteCnt <= 7'd0;
                            if (nextCnt == expBytes)
                            begin
                                cIdx  <= 5'd0;
                                state <= S_COMMIT; // RULE1 RULE14
                            end
                            else
                                reqDropped <= 1'b1; // RULE2
                        end
                        else
                            byteCnt <= nextCnt;
                    end
                end
                S_COMMIT:
                begin
                    if (stRdEn)
                        cIdx <= cIdx + 5'd1;
                    if (cPend)
                    begin
                        regWrValid <= pollConnOpen; // RULE15
                        regWrAddr  <= cmdReg(cPendIdx); // RULE9 RULE10 RULE13
                        regWrData  <= stRdData;
                        if (cPendIdx == 5'd0 && pollConnOpen)
                            ctrlWord <= stRdData; // RULE15
                    end
                    if (!stRdEn && !cPend)
                    begin
                        rIdx  <= 5'd0;
                        state <= S_RSP_RD; // RULE1
                    end
                end
                S_RSP_RD:
                    state <= S_RSP_LD;
                S_RSP_LD:
                begin
                    rspValid <= 1'b1;
                    rspData  <= statRdData[7:0]; // RULE17
                    rspLast  <= 1'b0;
                    state    <= S_RSP_LO;
                end
                S_RSP_LO:
                begin
                    if (rspReady)
                    begin
                        rspData <= statRdData[15:8]; // RULE17
                        rspLast <= (rIdx == rspWords - 5'd1); // RULE6 RULE7
                        state   <= S_RSP_HI;
                    end
                end
                S_RSP_HI:
                begin
                    if (rspReady)
                    begin
                        rspValid <= 1'b0;
                        rspLast  <= 1'b0;
                        if (rIdx == rspWords - 5'd1)
                            state <= S_RECV;
                        else
                        begin
                            rIdx  <= rIdx + 5'd1;
                            state <= S_RSP_RD; // RULE11 RULE12
                        end
                    end
                end
                default:
                    state <= S_RECV;
            endcase
        end
    end
endmodule // pdm_mapper

// ---- testbench/pdm_mapper_sva.sv ----
// Port-level properties of the poll data mapper.
`timescale 1ns/1ps
module pdm_mapper_sva (
    // Clock and reset
    input wire        clk,
    input wire        resetn,
    // Configuration
    input wire        extSet,
    input wire [1:0]  commLossSel,
    input wire        pollConnOpen,
    // Streams
    input wire        zeroReq,
    input wire        rspValid,
    input wire        rspReady,
    input wire [7:0]  rspData,
    input wire        rspLast,
    // Regulator side
    input wire        regWrValid,
    input wire [5:0]  regWrAddr,
    input wire [15:0] regWrData,
    input wire        commLossFault,
    input wire        reqDropped
);
    // ****
    // Reply byte counter
    // ****
    reg [4:0] rspCnt;
    always @(posedge clk)
    begin
        if (!resetn || (rspValid && rspReady && rspLast))
            rspCnt <= 5'h00;
        else if (rspValid && rspReady)
            rspCnt <= rspCnt + 5'h01;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    AST_RSP_HOLD: assert property (rspValid && !rspReady |=> rspValid && $stable(rspData)
        && $stable(rspLast)) else $error("reply byte changed while stalled");
    AST_WR_MAP: assert property (regWrValid |-> regWrAddr inside {[6'd32:6'd34], [6'd37:6'd49],
        6'd51, 6'd52, 6'd53, 6'd56, 6'd57, 6'd58, 6'd62}) else $error("write outside the poll group");
    AST_DROP_QUIET: assert property (reqDropped |-> ##1 (!rspValid && !regWrValid) [*8])
        else $error("dropped request still answered");
    AST_ZERO_STOP: assert property (zeroReq |-> ##[1:200] (regWrValid && regWrAddr == 6'd32
        && regWrData[1:0] == 2'h0)) else $error("zero request did not clear start and stop");
    AST_LOSS_FAULT: assert property ($fell(pollConnOpen) && commLossSel == 2'h1 |-> ##[1:4] commLossFault)
        else $error("connection loss did not fault");
    AST_GATE: assert property (regWrValid && regWrAddr != 6'd32 |-> pollConnOpen)
        else $error("write while connection closed");
    AST_ORDER: assert property (regWrValid && regWrAddr == 6'd33 |-> $past(regWrValid)
        && $past(regWrAddr) == 6'd32) else $error("speed reference not after control word");
    AST_RSP_LEN: assert property (rspValid && rspReady && rspLast |-> rspCnt == (extSet ? 5'd29 : 5'd17))
        else $error("reply length wrong");
    COV_EXT: cover property (rspValid && rspReady && rspLast && extSet);
    COV_DROP: cover property (reqDropped);
    COV_ZERO: cover property (zeroReq);
endmodule // pdm_mapper_sva

// ---- testbench/pdm_master_model.sv ----
// Behavioural network master that issues poll requests and collects replies.
`timescale 1ns/1ps
module pdm_master_model (
    // Clock
    input wire        clk,
    // Request stream
    output reg        reqValid,
    input wire        reqReady,
    output reg [7:0]  reqData,
    output reg        reqLast,
    // Reply stream
    input wire        rspValid,
    output reg        rspReady,
    input wire [7:0]  rspData,
    input wire        rspLast
);
    reg [8:0] rspQ[$];
    reg [1:0] stallCnt = 2'h0;
    initial
    begin
        reqValid = 1'b0;
        reqData = 8'h00;
        reqLast = 1'b0;
        rspReady = 1'b0;
    end
    function [15:0] reqWord(input int i);
        reqWord = 16'h8003 + 16'h0100 * i[7:0];
    endfunction
    // The master stalls one cycle in four so held reply bytes are exercised.
    always @(negedge clk)
    begin
        stallCnt <= stallCnt + 2'h1;
        rspReady <= stallCnt != 2'h3;
    end
    always @(posedge clk)
    begin
        if (rspValid && rspReady)
            rspQ.push_back({rspLast, rspData});
    end
    task sendMsg(input int n);
        int k;
        reg ok;
        reg [15:0] w;
        begin
            for (k = 0; k < n; k++)
            begin
                w = reqWord(k / 2);
                @(negedge clk);
                reqValid = 1'b1;
                reqData = k[0] ? w[15:8] : w[7:0];
                reqLast = (k == n - 1);
                ok = reqReady;
                while (!ok)
                begin
                    @(negedge clk);
                    ok = reqReady;
                end
            end
            @(negedge clk);
            reqValid = 1'b0;
            reqLast = 1'b0;
            reqData = ~reqData;
        end
    endtask
endmodule // pdm_master_model

// ---- testbench/pdm_mapper_tb_top.sv ----
// Self-checking testbench of the poll data mapper.
`timescale 1ns/1ps
module pdm_mapper_tb_top;
    reg clk = 1'b0;
    reg resetn = 1'b0;
    reg ce = 1'b1;
    reg extSet = 1'b0;
    reg [1:0] commLossSel = 2'h0;
    reg pollConnOpen = 1'b1;
    reg zeroReq = 1'b0;
    reg statWrEn = 1'b0;
    reg [5:0] statWrAddr = 6'h00;
    reg [15:0] statWrData = 16'h0000;
    wire reqValid, reqReady, reqLast, rspValid, rspReady, rspLast;
    wire regWrValid, commLossFault, reqDropped;
    wire [7:0] reqData, rspData;
    wire [5:0] regWrAddr;
    wire [15:0] regWrData, ctrlWord;
    reg [21:0] wq[$];
    reg dropSeen = 1'b0;
    int errorCnt = 0;
    int testsRun = 0;
    localparam [41:0] HI = {6'd62, 6'd58, 6'd57, 6'd56, 6'd53, 6'd52, 6'd51};
    initial forever #2.5 clk = ~clk;
    pdm_mapper DUT (.clk(clk), .resetn(resetn), .ce(ce), .extSet(extSet), .commLossSel(commLossSel),
        .pollConnOpen(pollConnOpen), .reqValid(reqValid), .reqReady(reqReady), .reqData(reqData),
        .reqLast(reqLast), .zeroReq(zeroReq), .rspValid(rspValid), .rspReady(rspReady), .rspData(rspData),
        .rspLast(rspLast), .statWrEn(statWrEn), .statWrAddr(statWrAddr), .statWrData(statWrData),
        .regWrValid(regWrValid), .regWrAddr(regWrAddr), .regWrData(regWrData), .ctrlWord(ctrlWord),
        .commLossFault(commLossFault), .reqDropped(reqDropped));
    pdm_master_model u_master (.clk(clk), .reqValid(reqValid), .reqReady(reqReady), .reqData(reqData),
        .reqLast(reqLast), .rspValid(rspValid), .rspReady(rspReady), .rspData(rspData), .rspLast(rspLast));
    always @(posedge clk)
    begin
        if (regWrValid)
            wq.push_back({regWrAddr, regWrData});
        if (reqDropped)
            dropSeen <= 1'b1;
    end
    function [5:0] cmdReg(input int i);
        cmdReg = (i < 16) ? ((i < 3) ? 6'd32 + i[5:0] : 6'd34 + i[5:0]) : HI[(i - 16) * 6 +: 6];
    endfunction
    function [15:0] stat(input [5:0] a);
        stat = {a, ~a, 4'h3};
    endfunction
    task check(input [31:0] seen, input [31:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            errorCnt++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task summarize;
        if (errorCnt == 0 && testsRun > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task waitCyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task runGood(input bit ext, input bit conn);
        int nw, nr, i, t;
        reg [15:0] w;
        begin
            nw = ext ? 23 : 3;
            nr = ext ? 15 : 9;
            extSet = ext;
            wq.delete();
            u_master.rspQ.delete();
            u_master.sendMsg(2 * nw);
            for (t = 0; u_master.rspQ.size() < 2 * nr && t < 800; t++)
                waitCyc(1);
            check(wq.size(), conn ? nw : 0);
            for (i = 0; i < wq.size(); i++)
                check(wq[i], {cmdReg(i), u_master.reqWord(i)});
            if (conn)
            begin
                check(ctrlWord, u_master.reqWord(0));
                check(u_master.rspQ.size(), 2 * nr);
                for (i = 0; i < 2 * nr; i++)
                begin
                    w = stat((i < 18) ? i / 2 : (i < 28) ? i / 2 + 3 : 6'd27);
                    check(u_master.rspQ[i], {i == 2 * nr - 1, i[0] ? w[15:8] : w[7:0]});
                end
            end
        end
    endtask
    task runBad(input bit ext, input int n);
        int t;
        begin
            extSet = ext;
            dropSeen = 1'b0;
            wq.delete();
            u_master.rspQ.delete();
            u_master.sendMsg(n);
            for (t = 0; !dropSeen && t < 200; t++)
                waitCyc(1);
            waitCyc(20);
            check(dropSeen, 1);
            check(wq.size() + u_master.rspQ.size(), 0);
        end
    endtask
    task runZero;
        int t;
        begin
            wq.delete();
            zeroReq = 1'b1;
            waitCyc(1);
            zeroReq = 1'b0;
            for (t = 0; wq.size() == 0 && t < 200; t++)
                waitCyc(1);
            check(wq[0], {6'd32, u_master.reqWord(0) & 16'hfffc});
            check(ctrlWord[1:0], 2'h0);
        end
    endtask
    task runLoss(input [1:0] sel);
        begin
            commLossSel = sel;
            pollConnOpen = 1'b0;
            waitCyc(5);
            check(commLossFault, sel == 2'h1);
            runGood(0, 0);
            pollConnOpen = 1'b1;
            waitCyc(5);
            check(commLossFault, 0);
        end
    endtask
    initial
    begin
        int a;
        waitCyc(6);
        resetn = 1'b1;
        for (a = 0; a < 64; a++)
        begin
            statWrEn = 1'b1;
            statWrAddr = a[5:0];
            statWrData = stat(a[5:0]);
            waitCyc(1);
        end
        statWrEn = 1'b0;
        runGood(0, 1);
        runGood(1, 1);
        runGood(0, 1);
        runBad(0, 4);
        runBad(0, 8);
        runBad(1, 6);
        runZero();
        runLoss(2'h0);
        runLoss(2'h1);
        summarize();
    end
    // The whole sequence needs well under 1,000 cycles; the limit leaves wide margin.
    initial
    begin
        #200000;
        errorCnt++;
        summarize();
    end
endmodule // pdm_mapper_tb_top
bind pdm_mapper pdm_mapper_sva u_sva (.clk(clk), .resetn(resetn), .extSet(extSet), .commLossSel(commLossSel),
    .pollConnOpen(pollConnOpen), .zeroReq(zeroReq), .rspValid(rspValid), .rspReady(rspReady),
    .rspData(rspData), .rspLast(rspLast), .regWrValid(regWrValid), .regWrAddr(regWrAddr),
    .regWrData(regWrData), .commLossFault(commLossFault), .reqDropped(reqDropped));
